/* File: pkg/shaacc_pkg.sv */
// Shared constants, register map and types of the hash accelerator
//
// Summary of operation
// - Algorithm select 0 gives SHA-1, 1 gives SHA-224, 2 gives SHA-256.
// - Start command hashes the message registers from built-in initial constants.
// - Resume command hashes the message registers from current hash register values.
// - Data is processed only as 512-bit blocks of sixteen 32-bit words.
// - Message word j sits in message register j, read in that order.
// - Busy reads 1 during a calculation and 0 once block or sequence ends.
// - Message registers may be rewritten while the previous block is hashed.
// - Hash registers and algorithm select are readable and writable between operations.
// - Processor mode interleaves per block; DMA mode only after the whole sequence.
// - One DMA calculation covers at most 63 blocks, count programmed beforehand.
// - In DMA mode all message data arrives over the DMA path.
// - DMA start hashes the programmed blocks from built-in initial constants.
// - DMA resume continues from hash register values loaded by software.
// - With done_irq_enable set, DMA completion raises the interrupt; never in processor mode.
// - Writing 1 to the interrupt clear command drops the pending interrupt.
// - On completion the digest is written into the hash registers.
// - Digest covers registers 0-4, 0-6 or 0-7 by algorithm.
// - Digest words stored most significant first, first word in hash register 0.
package shaacc_pkg;

  // Register byte offsets
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  REG_ALGO      = 8'h00;
  localparam logic [7:0]  REG_BLK_NUM   = 8'h0C;
  localparam logic [7:0]  REG_START     = 8'h10;
  localparam logic [7:0]  REG_RESUME    = 8'h14;
  localparam logic [7:0]  REG_BUSY      = 8'h18;
  localparam logic [7:0]  REG_DMA_START = 8'h1C;
  localparam logic [7:0]  REG_DMA_RESUM = 8'h20;
  localparam logic [7:0]  REG_IRQ_CLR   = 8'h24;
  localparam logic [7:0]  REG_IRQ_EN    = 8'h28;
  localparam logic [7:0]  REG_VERSION   = 8'h2C;
  localparam logic [7:0]  HASH_BASE     = 8'h40;
  localparam logic [7:0]  MSG_BASE      = 8'h80;

  // Field widths and encodings
  localparam int          ALGO_W        = 3;
  localparam int          BLK_W         = 6;
  localparam int          VER_W         = 30;
  localparam logic [2:0]  ALGO_SHA1     = 3'h0;
  localparam logic [2:0]  ALGO_SHA224   = 3'h1;
  localparam logic [2:0]  ALGO_SHA256   = 3'h2;
  localparam logic [6:0]  LAST_RND_SHA1 = 7'h4F;
  localparam logic [6:0]  LAST_RND_SHA2 = 7'h3F;
  localparam logic [3:0]  LAST_WORD     = 4'hF;

  // Round constants of the SHA-2 family
  localparam logic [0:63][31:0] K256 = '{
    32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5, 32'h3956C25B, 32'h59F111F1, 32'h923F82A4, 32'hAB1C5ED5,
    32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3, 32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174,
    32'hE49B69C1, 32'hEFBE4786, 32'h0FC19DC6, 32'h240CA1CC, 32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
    32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7, 32'hC6E00BF3, 32'hD5A79147, 32'h06CA6351, 32'h14292967,
    32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13, 32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85,
    32'hA2BFE8A1, 32'hA81A664B, 32'hC24B8B70, 32'hC76C51A3, 32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
    32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5, 32'h391C0CB3, 32'h4ED8AA4A, 32'h5B9CCA4F, 32'h682E6FF3,
    32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208, 32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};

  // Round constants of SHA-1, one per twenty rounds
  localparam logic [0:3][31:0] K1 = '{32'h5A827999, 32'h6ED9EBA1, 32'h8F1BBCDC, 32'hCA62C1D6};

  // Built-in initial hash values
  localparam logic [0:7][31:0] IV_SHA1 = '{
    32'h67452301, 32'hEFCDAB89, 32'h98BADCFE, 32'h10325476, 32'hC3D2E1F0, 32'h00000000, 32'h00000000, 32'h00000000};
  localparam logic [0:7][31:0] IV_SHA224 = '{
    32'hC1059ED8, 32'h367CD507, 32'h3070DD17, 32'hF70E5939, 32'hFFC00B31, 32'h68581511, 32'h64F98FA7, 32'hBEFA4FA4};
  localparam logic [0:7][31:0] IV_SHA256 = '{
    32'h6A09E667, 32'hBB67AE85, 32'h3C6EF372, 32'hA54FF53A, 32'h510E527F, 32'h9B05688C, 32'h1F83D9AB, 32'h5BE0CD19};

  // Engine states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_FILL  = 4'h2,
    ST_ROUND = 4'h4,
    ST_ADD   = 4'h8
  } shaacc_fsm_type;

  // Word stream from the DMA controller
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } shaacc_dma_type;

  // Whole state of the accelerator
  typedef struct packed {
    shaacc_fsm_type    state;
    logic              dma_mode;
    logic [ALGO_W-1:0] algo;
    logic [BLK_W-1:0]  blk_num;
    logic [BLK_W-1:0]  blk_left;
    logic              irq_en;
    logic              irq_pend;
    logic [VER_W-1:0]  version;
    logic [7:0][31:0]  hash;
    logic [15:0][31:0] msg;
    logic [15:0][31:0] w;
    logic [7:0][31:0]  v;
    logic [6:0]        round;
    logic [3:0]        wcnt;
    logic              ap_valid;
    logic              ap_write;
    logic [7:0]        ap_addr;
    logic [31:0]       rdata;
  } shaacc_state_type;

endpackage

/* File: rtl/shaacc_top.sv */
// Hash accelerator: AHB-Lite register slave, DMA word intake and SHA-1/224/256 round engine
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module shaacc_top
  import shaacc_pkg::*;
#(
  parameter int                MAX_BLOCKS = 63,
  parameter logic [VER_W-1:0]  VERSION    = 30'h0000001 // Arbitrary value
) (
  // Clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // AHB-Lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic            hready,
  input  wire logic [31:0]     hwdata,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // DMA word stream
  input  wire shaacc_dma_type  dma_in,
  output logic                 dma_ready,
  // Completion interrupt
  output logic                 done_irq
);

  // Refuse block counts the count field cannot hold
  if (MAX_BLOCKS < 1 || MAX_BLOCKS > 63) begin : g_chk
    $error("MAX_BLOCKS must lie in 1..63");
  end

  localparam logic [BLK_W-1:0] MAX_BLK = BLK_W'(MAX_BLOCKS);
  localparam shaacc_state_type RST_STATE = '{state: ST_IDLE, version: VERSION, default: '0};

  shaacc_state_type st_reg;
  shaacc_state_type st_next;

  // Right rotation of a word
  function automatic logic [31:0] ror(input logic [31:0] x, input int n);
    ror = (x >> n) | (x << (32 - n));
  endfunction

  // Initial hash values of the chosen algorithm
  function automatic logic [7:0][31:0] iv_of(input logic [ALGO_W-1:0] algo);
    logic [7:0][31:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      case (algo)
        ALGO_SHA1:   r[i] = IV_SHA1[i];
        ALGO_SHA224: r[i] = IV_SHA224[i];
        default:     r[i] = IV_SHA256[i];
      endcase
    end
    return r;
  endfunction

  // Register read mux, fed with the post-write state
  function automatic logic [31:0] rd_mux(input shaacc_state_type s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    if (a[7:5] == HASH_BASE[7:5]) begin
      r = s.hash[a[4:2]];
    end else if (a[7:6] == MSG_BASE[7:6]) begin
      r = s.msg[a[5:2]];
    end else begin
      case (a)
        REG_ALGO:    r = 32'(s.algo);
        REG_BLK_NUM: r = 32'(s.blk_num);
        REG_BUSY:    r = 32'(s.state != ST_IDLE);
        REG_IRQ_EN:  r = 32'(s.irq_en);
        REG_VERSION: r = 32'(s.version);
        default:     r = '0;
      endcase
    end
    return r;
  endfunction

  // Bus answers: never stalls, always OKAY; stream ready only while filling
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rdata;
  assign dma_ready = (st_reg.state == ST_FILL);
  assign done_irq  = st_reg.irq_pend & st_reg.irq_en;

  // Next-state logic: bus writes, commands, engine, read data
  always_comb begin
    logic        wr;
    logic        idle;
    logic        is_sha1;
    logic [7:0]  wa;
    logic [31:0] f;
    logic [31:0] t1;
    logic [31:0] t2;
    logic [31:0] wnew;
    logic [31:0] s0;
    logic [31:0] s1;
    logic [6:0]  last;
    wr      = 1'b0;
    idle    = 1'b0;
    is_sha1 = 1'b0;
    wa      = '0;
    f       = '0;
    t1      = '0;
    t2      = '0;
    wnew    = '0;
    s0      = '0;
    s1      = '0;
    last    = '0;
    st_next = st_reg;
    wr      = st_reg.ap_valid & st_reg.ap_write;
    wa      = st_reg.ap_addr;
    idle    = (st_reg.state == ST_IDLE);
    is_sha1 = (st_reg.algo == ALGO_SHA1);
    last    = is_sha1 ? LAST_RND_SHA1 : LAST_RND_SHA2;

    // Message registers stay writable at all times; the engine works on its own copy
    if (wr && wa[7:6] == MSG_BASE[7:6]) begin
      st_next.msg[wa[5:2]] = hwdata;
    end
    // Bus writes to hash registers and configuration only take effect while idle
    if (wr && idle && wa[7:5] == HASH_BASE[7:5]) begin
      st_next.hash[wa[4:2]] = hwdata;
    end
    if (wr && idle) begin
      case (wa)
        REG_ALGO:    st_next.algo = hwdata[ALGO_W-1:0];
        REG_BLK_NUM: st_next.blk_num = (hwdata[BLK_W-1:0] > MAX_BLK) ? MAX_BLK : hwdata[BLK_W-1:0];
        REG_IRQ_EN:  st_next.irq_en = hwdata[0];
        REG_VERSION: st_next.version = hwdata[VER_W-1:0];
        default:     ;
      endcase
    end
    if (wr && wa == REG_IRQ_CLR && hwdata[0]) begin
      st_next.irq_pend = 1'b0;
    end

    // Engine
    case (st_reg.state)
      ST_IDLE: begin
        // Start and resume commands are taken only while idle; such writes during a run are dropped
        if (wr && hwdata[0]) begin
          case (wa)
            REG_START: begin
              st_next.hash     = iv_of(st_reg.algo);
              st_next.v        = iv_of(st_reg.algo);
              st_next.w        = st_reg.msg;
              st_next.round    = '0;
              st_next.dma_mode = 1'b0;
              st_next.state    = ST_ROUND;
            end
            REG_RESUME: begin
              st_next.v        = st_reg.hash;
              st_next.w        = st_reg.msg;
              st_next.round    = '0;
              st_next.dma_mode = 1'b0;
              st_next.state    = ST_ROUND;
            end
            REG_DMA_START, REG_DMA_RESUM: begin
              if (wa == REG_DMA_START) begin
                st_next.hash = iv_of(st_reg.algo);
              end
              st_next.dma_mode = 1'b1;
              st_next.blk_left = st_reg.blk_num;
              st_next.wcnt     = '0;
              if (st_reg.blk_num == '0) begin
                st_next.irq_pend = 1'b1;
              end else begin
                st_next.state = ST_FILL;
              end
            end
            default: ;
          endcase
        end
      end
      ST_FILL: begin
        // Sixteen stream words make one block, word 0 first
        if (dma_in.valid) begin
          st_next.w[st_reg.wcnt] = dma_in.data;
          st_next.wcnt           = st_reg.wcnt + 4'h1;
          if (st_reg.wcnt == LAST_WORD) begin
            st_next.v     = st_reg.hash;
            st_next.round = '0;
            st_next.state = ST_ROUND;
          end
        end
      end
      ST_ROUND: begin
        // One round a cycle, sixteen-word sliding schedule, oldest word at index 0
        if (is_sha1) begin
          if (st_reg.round < 7'd20) begin
            f = (st_reg.v[1] & st_reg.v[2]) | (~st_reg.v[1] & st_reg.v[3]);
          end else if (st_reg.round >= 7'd40 && st_reg.round < 7'd60) begin
            f = (st_reg.v[1] & st_reg.v[2]) | (st_reg.v[1] & st_reg.v[3]) | (st_reg.v[2] & st_reg.v[3]);
          end else begin
            f = st_reg.v[1] ^ st_reg.v[2] ^ st_reg.v[3];
          end
          t1   = ror(st_reg.v[0], 27) + f + st_reg.v[4] + K1[st_reg.round / 7'd20] + st_reg.w[0];
          wnew = ror(st_reg.w[13] ^ st_reg.w[8] ^ st_reg.w[2] ^ st_reg.w[0], 31);
          st_next.v[4] = st_reg.v[3];
          st_next.v[3] = st_reg.v[2];
          st_next.v[2] = ror(st_reg.v[1], 2);
          st_next.v[1] = st_reg.v[0];
          st_next.v[0] = t1;
        end else begin
          t1 = st_reg.v[7] + (ror(st_reg.v[4], 6) ^ ror(st_reg.v[4], 11) ^ ror(st_reg.v[4], 25))
             + ((st_reg.v[4] & st_reg.v[5]) ^ (~st_reg.v[4] & st_reg.v[6]))
             + K256[st_reg.round[5:0]] + st_reg.w[0];
          t2 = (ror(st_reg.v[0], 2) ^ ror(st_reg.v[0], 13) ^ ror(st_reg.v[0], 22))
             + ((st_reg.v[0] & st_reg.v[1]) ^ (st_reg.v[0] & st_reg.v[2]) ^ (st_reg.v[1] & st_reg.v[2]));
          s0   = ror(st_reg.w[1], 7) ^ ror(st_reg.w[1], 18) ^ (st_reg.w[1] >> 3);
          s1   = ror(st_reg.w[14], 17) ^ ror(st_reg.w[14], 19) ^ (st_reg.w[14] >> 10);
          wnew = s1 + st_reg.w[9] + s0 + st_reg.w[0];
          st_next.v[7] = st_reg.v[6];
          st_next.v[6] = st_reg.v[5];
          st_next.v[5] = st_reg.v[4];
          st_next.v[4] = st_reg.v[3] + t1;
          st_next.v[3] = st_reg.v[2];
          st_next.v[2] = st_reg.v[1];
          st_next.v[1] = st_reg.v[0];
          st_next.v[0] = t1 + t2;
        end
        st_next.w     = {wnew, st_reg.w[15:1]};
        st_next.round = st_reg.round + 7'h1;
        if (st_reg.round == last) begin
          st_next.state = ST_ADD;
        end
      end
      ST_ADD: begin
        // Fold the working variables into the hash registers, word 0 most significant
        for (int i = 0; i < 8; i++) begin
          if (!is_sha1 || i < 5) begin
            st_next.hash[i] = st_reg.hash[i] + st_reg.v[i];
          end
        end
        if (st_reg.dma_mode && st_reg.blk_left > BLK_W'(1)) begin
          st_next.blk_left = st_reg.blk_left - BLK_W'(1);
          st_next.wcnt     = '0;
          st_next.state    = ST_FILL;
        end else begin
          st_next.state = ST_IDLE;
          if (st_reg.dma_mode) begin
            st_next.irq_pend = 1'b1;
          end
        end
      end
      default: st_next.state = ST_IDLE;
    endcase

    // Address phase capture; read data is taken from the state after any pending write
    if (hready) begin
      st_next.ap_valid = hsel & htrans[1];
      st_next.ap_write = hwrite;
      st_next.ap_addr  = haddr[ADDR_W-1:0];
      if (hsel && htrans[1] && !hwrite) begin
        st_next.rdata = rd_mux(st_next, haddr[ADDR_W-1:0]);
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= RST_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

/* File: verif/shaacc_monitor.sv */
// Assertion checker for the bus, stream and interrupt ports of the hash accelerator
`timescale 1ns/1ps
module shaacc_monitor
  import shaacc_pkg::*;
(
  // Clock and reset
  input wire logic           hclk,
  input wire logic           hresetn,
  // Bus
  input wire logic           hsel,
  input wire logic [31:0]    haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic           hready,
  input wire logic [31:0]    hwdata,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire logic [31:0]    hrdata,
  // Stream and interrupt
  input wire shaacc_dma_type dma_in,
  input wire logic           dma_ready,
  input wire logic           done_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       ph_reg;
  logic       ph_wr_reg;
  logic [7:0] ph_a_reg;
  logic [3:0] wc_reg;
  logic       wr_cmd;
  // Data-phase tracking and count of stream words taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg    <= 1'b0;
      ph_wr_reg <= 1'b0;
      ph_a_reg  <= 8'h00;
      wc_reg    <= 4'h0;
    end else begin
      ph_reg    <= hsel && htrans[1] && hready;
      ph_wr_reg <= hwrite;
      ph_a_reg  <= haddr[7:0];
      if (dma_in.valid && dma_ready) begin
        wc_reg <= wc_reg + 4'h1;
      end
    end
  end
  // Processor start in its write data phase
  assign wr_cmd = ph_reg && ph_wr_reg && ph_a_reg == REG_START && hwdata[0];
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_irq_clr;
    ph_reg && ph_wr_reg && ph_a_reg == REG_IRQ_CLR && hwdata[0] |=> !done_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt kept after clear");
  property p_fill_end;
    $fell(dma_ready) |-> $past(dma_in.valid) && $past(wc_reg) == LAST_WORD;
  endproperty
  a_fill_end: assert property (p_fill_end) else $error("fill ended before sixteen words");
  property p_round_gap;
    $fell(dma_ready) |-> !dma_ready [*8];
  endproperty
  a_round_gap: assert property (p_round_gap) else $error("stream reopened during rounds");
  property p_no_proc_irq;
    wr_cmd && !done_irq |=> !done_irq [*8];
  endproperty
  a_no_proc_irq: assert property (p_no_proc_irq) else $error("interrupt in processor mode");
  property p_no_dma_proc;
    wr_cmd |=> !dma_ready [*8];
  endproperty
  a_no_dma_proc: assert property (p_no_dma_proc) else $error("stream opened in processor mode");
  property p_busy_bits;
    ph_reg && !ph_wr_reg && ph_a_reg == REG_BUSY |-> hrdata[31:1] == 31'h0;
  endproperty
  a_busy_bits: assert property (p_busy_bits) else $error("busy word has upper bits");
  property p_algo_bits;
    ph_reg && !ph_wr_reg && ph_a_reg == REG_ALGO |-> hrdata[31:3] == 29'h0;
  endproperty
  a_algo_bits: assert property (p_algo_bits) else $error("algorithm word has upper bits");
  property p_unmapped;
    ph_reg && !ph_wr_reg && ph_a_reg == 8'h04 |-> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind shaacc_top shaacc_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .dma_in(dma_in), .dma_ready(dma_ready), .done_irq(done_irq));

/* File: verif/shaacc_dma_model.sv */
// Behavioural DMA controller that feeds queued words into the accelerator stream
`timescale 1ns/1ps
module shaacc_dma_model
  import shaacc_pkg::*;
(
  // Clock, reset and stall control
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      slow,
  // Word stream
  input  wire logic      dma_ready,
  output shaacc_dma_type dma_out
);
  logic [31:0] q[$];
  logic        gap_reg;
  // Words queued by the bench before a run
  task automatic load(input logic [31:0] w);
    q.push_back(w);
  endtask
  // Hold an offered word until taken; when slow, pause every other cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_out <= '0;
      gap_reg <= 1'b0;
    end else if (!dma_out.valid || dma_ready) begin
      if (dma_out.valid) begin
        void'(q.pop_front());
      end
      gap_reg <= slow && !gap_reg;
      if (q.size() > 0 && !(slow && !gap_reg)) begin
        dma_out.valid <= 1'b1;
        dma_out.data  <= q[0];
      end else begin
        dma_out.valid <= 1'b0;
        dma_out.data  <= ~dma_out.data; // Stale data flips so it never looks valid
      end
    end
  end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the hash accelerator
`timescale 1ns/1ps
module tb
  import shaacc_pkg::*;
();
  localparam logic [VER_W-1:0] VER = 30'h0000ABC; // Arbitrary value
  localparam logic [2:0] R_ALGO [3] = '{ALGO_SHA1, ALGO_SHA224, ALGO_SHA256};
  localparam int R_N [3] = '{5, 7, 8};
  localparam logic [255:0] R_DIG [3] = '{{160'hA9993E364706816ABA3E25717850C26C9CD0D89D, 96'h0},
    {224'h23097D223405D8228642A477BDA255B32AADBCE4BDA0B3F7E36C9DA7, 32'h0},
    256'hBA7816BF8F01CFEA414140DE5DAE2223B00361A396177A9CB410FF61F20015AD};
  localparam logic [255:0] DIG2 = 256'h248D6A61D20638B8E5C026930C3E6039A33CE45964FF2167F6ECEDD419DB06C1;
  logic           hclk = 1'b0;
  logic           hresetn, hsel, hwrite, slow, hreadyout, hresp, dma_ready, done_irq;
  logic [31:0]    haddr, hwdata, hrdata, rd;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [31:0]    sv [8];
  shaacc_dma_type dma_in;
  int             n_errors = 0;
  int             cmp_count = 0;
  // Clock and design
  always #4 hclk = ~hclk;
  shaacc_top #(.MAX_BLOCKS(63), .VERSION(VER)) u_shaacc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dma_in(dma_in), .dma_ready(dma_ready),
    .done_irq(done_irq));
  shaacc_dma_model u_dma (.hclk(hclk), .hresetn(hresetn), .slow(slow), .dma_ready(dma_ready), .dma_out(dma_in));
  // One single bus transfer, held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Poll busy under a bounded count
  task automatic idle();
    int k = 0;
    do begin
      bus(1'b0, REG_BUSY, 32'h0);
      k++;
    end while (rd !== 32'h0 && k < 300);
    chk(rd, 32'h0);
  endtask
  // Message words: 0 short block, 1 and 2 the two blocks of the long message
  function automatic logic [31:0] mw(input int kind, input int j);
    logic [7:0] b = 8'(j);
    case (kind)
      0: return j == 0 ? 32'h61626380 : (j == 15 ? 32'h00000018 : 32'h0);
      1: return j < 14 ? {8'h61 + b, 8'h62 + b, 8'h63 + b, 8'h64 + b} : (j == 14 ? 32'h80000000 : 32'h0);
      default: return j == 15 ? 32'h000001C0 : 32'h0;
    endcase
  endfunction
  task automatic go(input int kind, input logic [2:0] al, input logic [7:0] cmd);
    for (int j = 0; j < 16 && kind >= 0; j++) bus(1'b1, MSG_BASE + 8'(4 * j), mw(kind, j));
    bus(1'b1, REG_ALGO, {29'h0, al});
    bus(1'b1, cmd, 32'h1);
  endtask
  task automatic dig(input logic [255:0] d, input int n);
    for (int k = 0; k < n; k++) rdchk(HASH_BASE + 8'(4 * k), d[255 - 32 * k -: 32]);
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #300000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
  // Main sequence
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, slow, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(REG_ALGO, 32'h0);
    rdchk(REG_BUSY, 32'h0);
    rdchk(REG_VERSION, {2'b00, VER});
    rdchk(HASH_BASE, 32'h0);
    rdchk(8'h04, 32'h0);
    bus(1'b1, REG_BLK_NUM, 32'h0000003F);
    rdchk(REG_BLK_NUM, 32'h0000003F);
    $display("Test reset values done");
    bus(1'b1, REG_IRQ_EN, 32'h1);
    for (int r = 0; r < 3; r++) begin
      go(0, R_ALGO[r], REG_START);
      idle();
      dig(R_DIG[r], R_N[r]);
      chk({31'h0, done_irq}, 32'h0);
    end
    $display("Test algorithm rows done");
    go(1, ALGO_SHA256, REG_START);
    rdchk(REG_BUSY, 32'h1);
    bus(1'b1, HASH_BASE, 32'h0);
    for (int j = 0; j < 16; j++) bus(1'b1, MSG_BASE + 8'(4 * j), mw(2, j));
    idle();
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, HASH_BASE + 8'(4 * k), 32'h0);
      sv[k] = rd;
    end
    go(0, ALGO_SHA1, REG_START);
    idle();
    dig(R_DIG[0], 5);
    for (int k = 0; k < 8; k++) bus(1'b1, HASH_BASE + 8'(4 * k), sv[k]);
    go(2, ALGO_SHA256, REG_RESUME);
    idle();
    dig(DIG2, 8);
    $display("Test interleaved chain done");
    slow <= 1'b1;
    for (int j = 0; j < 32; j++) u_dma.load(mw(1 + j / 16, j % 16));
    bus(1'b1, REG_BLK_NUM, 32'h2);
    go(-1, ALGO_SHA256, REG_DMA_START);
    bus(1'b1, REG_RESUME, 32'h1);
    for (int j = 0; j < 16; j++) bus(1'b1, MSG_BASE + 8'(4 * j), mw(0, j));
    idle();
    dig(DIG2, 8);
    chk({31'h0, done_irq}, 32'h1);
    bus(1'b1, REG_IRQ_CLR, 32'h1);
    @(posedge hclk);
    chk({31'h0, done_irq}, 32'h0);
    $display("Test stream two blocks done");
    slow <= 1'b0;
    bus(1'b1, REG_IRQ_EN, 32'h0);
    bus(1'b1, REG_BLK_NUM, 32'h1);
    for (int j = 0; j < 16; j++) u_dma.load(mw(1, j));
    go(-1, ALGO_SHA256, REG_DMA_START);
    idle();
    chk({31'h0, done_irq}, 32'h0);
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, HASH_BASE + 8'(4 * k), 32'h0);
      bus(1'b1, HASH_BASE + 8'(4 * k), rd);
    end
    for (int j = 0; j < 16; j++) u_dma.load(mw(2, j));
    go(-1, ALGO_SHA256, REG_DMA_RESUM);
    idle();
    dig(DIG2, 8);
    $display("Test stream chain done");
    bus(1'b1, REG_IRQ_CLR, 32'h1);
    bus(1'b1, REG_IRQ_EN, 32'h1);
    chk({31'h0, done_irq}, 32'h0);
    bus(1'b1, REG_BLK_NUM, 32'h0);
    bus(1'b1, REG_DMA_START, 32'h1);
    rdchk(REG_BUSY, 32'h0);
    chk({31'h0, done_irq}, 32'h1);
    bus(1'b1, REG_IRQ_CLR, 32'h1);
    @(posedge hclk);
    chk({31'h0, done_irq}, 32'h0);
    $display("Test empty stream done");
    close_out();
  end
endmodule
